/* File: hw/cssc_defs.svh */
`ifndef CSSC_DEFS_SVH
`define CSSC_DEFS_SVH

// Register byte offsets
`define CSSC_OFS_FORCE 8'h0c
`define CSSC_OFS_CTRL 8'h10
`define CSSC_OFS_STATUS 8'h14

// Socket control fields
`define CSSC_CTRL_RESET 32'h0000_0400
`define CSSC_BIT_ACTIVITY 11
`define CSSC_BIT_STDCAP 10
`define CSSC_BIT_VIDEN 9
`define CSSC_BIT_CLKSEL 7
`define CSSC_MAIN_LSB 4
`define CSSC_PROG_LSB 0

// Force register fields
`define CSSC_BIT_INTERROGATE 14
`define CSSC_FORCE_MSB 13
`define CSSC_FORCE_LSB 10

// Status register fields
`define CSSC_BIT_PWREN 0
`define CSSC_BIT_REFUSED 1
`define CSSC_BIT_CLKSTOP 2
`define CSSC_MAINGR_LSB 8
`define CSSC_PROGGR_LSB 12

// Supply codes, main supply
`define CSSC_VCC_OFF 3'b000
`define CSSC_VCC_5V 3'b010
`define CSSC_VCC_3V3 3'b011
`define CSSC_VCC_X 3'b100
`define CSSC_VCC_Y 3'b101

// Supply codes, programming supply
`define CSSC_VPP_OFF 3'b000
`define CSSC_VPP_12V 3'b001
`define CSSC_VPP_5V 3'b010
`define CSSC_VPP_3V3 3'b011
`define CSSC_VPP_X 3'b100
`define CSSC_VPP_Y 3'b101

// Idle clock count before a clock stop
`define CSSC_IDLE_CLOCKS 8
`define CSSC_CNT_W 8

`endif

/* File: hw/cssc_pkg.sv */
`include "cssc_defs.svh"

package cssc_pkg;

  // Clock-run state
  typedef enum logic [1:0] {
    CSSC_CR_RUN = 2'b01,
    CSSC_CR_STOP = 2'b10
  } cssc_clk_state_t;

  // Whole state of the socket control block
  typedef struct packed {
    logic videoEn;
    logic clkStopSel;
    logic [2:0] mainReq;
    logic [2:0] progReq;
    logic pwrCtrlEn;
    logic interrogate;
    logic ack;
    logic [31:0] rdata;
    logic [`CSSC_CNT_W-1:0] idleCnt;
    cssc_clk_state_t clkState;
    logic [2:0] mainGrant;
    logic [2:0] progGrant;
    logic refused;
  } cssc_state_t;

  // Main supply code against card sense {Y,X,3V3,5V}
  function automatic logic csscVccAccepted(input logic [2:0] code, input logic [3:0] sense);
    case (code)
      `CSSC_VCC_5V: csscVccAccepted = sense[0];
      `CSSC_VCC_3V3: csscVccAccepted = sense[1];
      `CSSC_VCC_X: csscVccAccepted = sense[2];
      `CSSC_VCC_Y: csscVccAccepted = sense[3];
      default: csscVccAccepted = 1'b0;
    endcase
  endfunction : csscVccAccepted

  // Programming supply code against card sense
  function automatic logic csscVppAccepted(input logic [2:0] code, input logic [3:0] sense);
    case (code)
      `CSSC_VPP_12V: csscVppAccepted = 1'b1;
      `CSSC_VPP_5V: csscVppAccepted = sense[0];
      `CSSC_VPP_3V3: csscVppAccepted = sense[1];
      `CSSC_VPP_X: csscVppAccepted = sense[2];
      `CSSC_VPP_Y: csscVppAccepted = sense[3];
      default: csscVppAccepted = 1'b0;
    endcase
  endfunction : csscVppAccepted

endpackage : cssc_pkg

/* File: hw/cssc_supply_gate.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.svh"

module cssc_supply_gate
  import cssc_pkg::*;
(
  input wire logic [2:0] mainReq,
  input wire logic [2:0] progReq,
  input wire logic pwrCtrlEn,
  input wire logic cardIsCardBus,
  input wire logic [3:0] cardSense,
  output logic [2:0] mainGrant,
  output logic [2:0] progGrant,
  output logic refused
);

  logic [3:0] effSense;
  logic mainOk;
  logic progOk;

  // 16-bit cards take any defined level; card-bus cards only sensed ones and 12 V programming
  assign effSense = cardIsCardBus ? cardSense : 4'hf;
  assign mainOk = pwrCtrlEn & csscVccAccepted(mainReq, effSense);
  assign progOk = mainOk & csscVppAccepted(progReq, effSense);

  // Refused requests leave that supply off
  assign mainGrant = mainOk ? mainReq : `CSSC_VCC_OFF;
  assign progGrant = progOk ? progReq : `CSSC_VPP_OFF;
  assign refused = ((mainReq != `CSSC_VCC_OFF) & ~mainOk)
                 | ((progReq != `CSSC_VPP_OFF) & ~progOk);

endmodule : cssc_supply_gate
`default_nettype wire

/* File: hw/cssc_socket_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.svh"

module cssc_socket_ctrl
  import cssc_pkg::*;
#(
  parameter int IDLE_CLOCKS = `CSSC_IDLE_CLOCKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic cardIdle,
  input wire logic hostStopReq,
  input wire logic cardIsCardBus,
  input wire logic [3:0] cardSense,
  output logic cardClockStop,
  output logic videoPortEnable,
  output logic videoPortActivity,
  output logic [2:0] mainSupplyGrant,
  output logic [2:0] progSupplyGrant,
  output logic supplyRefused,
  output logic powerCtrlEnabled,
  output logic cardInterrogatePulse
);

  // Refuse counts the counter cannot hold
  if (IDLE_CLOCKS < 1 || IDLE_CLOCKS > 255) begin : gBadIdle
    $error("IDLE_CLOCKS must lie in 1..255");
  end

  localparam logic [`CSSC_CNT_W-1:0] IdleLast = `CSSC_CNT_W'(IDLE_CLOCKS - 1);

  cssc_state_t s_q;
  cssc_state_t s_d;
  logic [2:0] gateMain;
  logic [2:0] gateProg;
  logic gateRefused;
  logic wrAccept;
  logic rdFirst;
  logic idleReached;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;

  // Control word assembly; fixed bits are constants, not state
  function automatic logic [31:0] buildCtrl(input cssc_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CSSC_BIT_ACTIVITY] = st.videoEn;
    w[`CSSC_BIT_STDCAP] = 1'b1;
    w[`CSSC_BIT_VIDEN] = st.videoEn;
    w[`CSSC_BIT_CLKSEL] = st.clkStopSel;
    w[`CSSC_MAIN_LSB +: 3] = st.mainReq;
    w[`CSSC_PROG_LSB +: 3] = st.progReq;
    return w;
  endfunction : buildCtrl

  // Status word assembly
  function automatic logic [31:0] buildStatus(input cssc_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CSSC_BIT_PWREN] = st.pwrCtrlEn;
    w[`CSSC_BIT_REFUSED] = st.refused;
    w[`CSSC_BIT_CLKSTOP] = (st.clkState == CSSC_CR_STOP);
    w[`CSSC_MAINGR_LSB +: 3] = st.mainGrant;
    w[`CSSC_PROGGR_LSB +: 3] = st.progGrant;
    return w;
  endfunction : buildStatus

  assign ctrlWord = buildCtrl(s_q);
  assign statusWord = buildStatus(s_q);

  // Supply acceptance check
  cssc_supply_gate uGate (
    .mainReq(s_q.mainReq),
    .progReq(s_q.progReq),
    .pwrCtrlEn(s_q.pwrCtrlEn),
    .cardIsCardBus(cardIsCardBus),
    .cardSense(cardSense),
    .mainGrant(gateMain),
    .progGrant(gateProg),
    .refused(gateRefused)
  );

  // Bus handshake: one wait cycle, then accept
  assign waitrequest = (read | write) & ~s_q.ack;
  assign wrAccept = write & s_q.ack;
  assign rdFirst = read & ~s_q.ack;
  assign idleReached = cardIdle & (s_q.idleCnt >= IdleLast);

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ack = (read | write) & ~s_q.ack;
    s_d.interrogate = 1'b0;
    // Read data captured in the wait cycle, unmapped reads give zero
    if (rdFirst) begin
      case (address)
        `CSSC_OFS_CTRL: s_d.rdata = ctrlWord;
        `CSSC_OFS_STATUS: s_d.rdata = statusWord;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Only writable fields take bus data
    if (wrAccept && address == `CSSC_OFS_CTRL) begin
      if (byteenable[0]) begin
        s_d.clkStopSel = writedata[`CSSC_BIT_CLKSEL];
        s_d.mainReq = writedata[`CSSC_MAIN_LSB +: 3];
        s_d.progReq = writedata[`CSSC_PROG_LSB +: 3];
      end
      if (byteenable[1]) begin
        s_d.videoEn = writedata[`CSSC_BIT_VIDEN];
      end
    end
    // Forcing sense disables power; interrogation wins and re-enables
    if (wrAccept && address == `CSSC_OFS_FORCE && byteenable[1]) begin
      if (|writedata[`CSSC_FORCE_MSB:`CSSC_FORCE_LSB]) begin
        s_d.pwrCtrlEn = 1'b0;
      end
      if (writedata[`CSSC_BIT_INTERROGATE]) begin
        s_d.pwrCtrlEn = 1'b1;
        s_d.interrogate = 1'b1;
      end
    end
    // Consecutive idle cycles, saturating
    if (!cardIdle) begin
      s_d.idleCnt = '0;
    end else if (s_q.idleCnt != {`CSSC_CNT_W{1'b1}}) begin
      s_d.idleCnt = s_q.idleCnt + `CSSC_CNT_W'(1);
    end
    // Clock-run decision
    case (s_q.clkState)
      CSSC_CR_RUN: begin
        if (idleReached && (s_q.clkStopSel || hostStopReq)) begin
          s_d.clkState = CSSC_CR_STOP;
        end
      end
      CSSC_CR_STOP: begin
        if (!cardIdle || (!s_q.clkStopSel && !hostStopReq)) begin
          s_d.clkState = CSSC_CR_RUN;
        end
      end
      default: s_d.clkState = CSSC_CR_RUN;
    endcase
    // Granted supplies held in flops
    s_d.mainGrant = gateMain;
    s_d.progGrant = gateProg;
    s_d.refused = gateRefused;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q.videoEn <= 1'b0;
      s_q.clkStopSel <= 1'b0;
      s_q.mainReq <= `CSSC_VCC_OFF;
      s_q.progReq <= `CSSC_VPP_OFF;
      s_q.pwrCtrlEn <= 1'b1;
      s_q.interrogate <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.idleCnt <= '0;
      s_q.clkState <= CSSC_CR_RUN;
      s_q.mainGrant <= `CSSC_VCC_OFF;
      s_q.progGrant <= `CSSC_VPP_OFF;
      s_q.refused <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign readdata = s_q.rdata;
  assign cardClockStop = (s_q.clkState == CSSC_CR_STOP);
  assign videoPortEnable = s_q.videoEn;
  assign videoPortActivity = ctrlWord[`CSSC_BIT_ACTIVITY];
  assign mainSupplyGrant = s_q.mainGrant;
  assign progSupplyGrant = s_q.progGrant;
  assign supplyRefused = s_q.refused;
  assign powerCtrlEnabled = s_q.pwrCtrlEn;
  assign cardInterrogatePulse = s_q.interrogate;

  // Checks
  logic rdCtrlDone;
  assign rdCtrlDone = read & ~waitrequest & (address == `CSSC_OFS_CTRL);

  AST_RESET_VALUE: assert property (@(posedge clk)
    $past(!rst_b) |-> ctrlWord == `CSSC_CTRL_RESET)
    else $error("control word not at reset value");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    rdCtrlDone |-> (readdata[31:12] == 20'h0_0000) && !readdata[8] && !readdata[3])
    else $error("reserved control bits read nonzero");

  AST_ACTIVITY: assert property (@(posedge clk) disable iff (!rst_b)
    rdCtrlDone |-> readdata[`CSSC_BIT_ACTIVITY] == readdata[`CSSC_BIT_VIDEN])
    else $error("activity readback disagrees with enable");

  AST_STD_CAP: assert property (@(posedge clk) disable iff (!rst_b)
    rdCtrlDone |-> readdata[`CSSC_BIT_STDCAP])
    else $error("model capability bit not set");

  AST_VIDEO_EN: assert property (@(posedge clk) disable iff (!rst_b)
    (wrAccept && address == `CSSC_OFS_CTRL && byteenable[1])
      |=> videoPortEnable == $past(writedata[`CSSC_BIT_VIDEN]) ##1 videoPortActivity == videoPortEnable)
    else $error("video enable not taken from write");

  AST_HOST_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(cardClockStop) && !$past(s_q.clkStopSel)) |-> $past(hostStopReq) && $past(cardIdle))
    else $error("clock stopped without host request and idle card");

  AST_AUTO_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.clkStopSel && cardIdle)[*8] |=> cardClockStop)
    else $error("clock not stopped after idle count");

  AST_MAIN_CODE: assert property (@(posedge clk) disable iff (!rst_b)
    mainSupplyGrant inside {`CSSC_VCC_OFF, `CSSC_VCC_5V, `CSSC_VCC_3V3, `CSSC_VCC_X, `CSSC_VCC_Y})
    else $error("reserved main supply code granted");

  AST_PROG_CODE: assert property (@(posedge clk) disable iff (!rst_b)
    progSupplyGrant[2:1] != 2'b11)
    else $error("reserved programming supply code granted");

  AST_ACCEPTED_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    (mainSupplyGrant == `CSSC_VCC_5V && $past(cardIsCardBus)) |-> $past(cardSense[0]) && $past(powerCtrlEnabled))
    else $error("5 V granted to a card that does not accept it");

  AST_FORCE_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    (wrAccept && address == `CSSC_OFS_FORCE && byteenable[1] && writedata[`CSSC_FORCE_LSB]
      && !writedata[`CSSC_BIT_INTERROGATE]) |=> !powerCtrlEnabled ##1 mainSupplyGrant == `CSSC_VCC_OFF)
    else $error("forced sense left power control on");

  AST_FIXED_BITS: assert property (@(posedge clk) disable iff (!rst_b)
    (wrAccept && address == `CSSC_OFS_CTRL)
      |=> (ctrlWord[31:12] == 20'h0_0000) && ctrlWord[10] && !ctrlWord[8] && !ctrlWord[3])
    else $error("write disturbed fixed control bits");

  // Byte lanes, read-only space and supply gating
  AST_LANE_ONE_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
    (wrAccept && address == `CSSC_OFS_CTRL && !byteenable[1]) |=> $stable(videoPortEnable))
    else $error("video enable changed without its byte lane");

  AST_STATUS_READ_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
    (wrAccept && address == `CSSC_OFS_STATUS) |=> $stable(ctrlWord) && $stable(powerCtrlEnabled))
    else $error("write to status space changed state");

  AST_ACCEPTED_3V3: assert property (@(posedge clk) disable iff (!rst_b)
    (mainSupplyGrant == `CSSC_VCC_3V3 && $past(cardIsCardBus))
      |-> $past(cardSense[1]) && $past(powerCtrlEnabled))
    else $error("3.3 V granted to a card that does not accept it");

  AST_PROG_NEEDS_MAIN: assert property (@(posedge clk) disable iff (!rst_b)
    (progSupplyGrant != `CSSC_VPP_OFF) |-> (mainSupplyGrant != `CSSC_VCC_OFF))
    else $error("programming supply granted without main supply");

  AST_REFUSED_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(s_q.mainReq) != `CSSC_VCC_OFF && mainSupplyGrant == `CSSC_VCC_OFF) |-> supplyRefused)
    else $error("refused main request not flagged");

  AST_GATED_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(powerCtrlEnabled)
      |-> (mainSupplyGrant == `CSSC_VCC_OFF) && (progSupplyGrant == `CSSC_VPP_OFF))
    else $error("supply granted while power control disabled");

  AST_INTERROGATE: assert property (@(posedge clk) disable iff (!rst_b)
    (wrAccept && address == `CSSC_OFS_FORCE && byteenable[1] && writedata[`CSSC_BIT_INTERROGATE])
      |=> powerCtrlEnabled && cardInterrogatePulse)
    else $error("interrogation did not re-enable power control");

  AST_PULSE_SINGLE: assert property (@(posedge clk) disable iff (!rst_b)
    cardInterrogatePulse |=> !cardInterrogatePulse)
    else $error("interrogation pulse longer than one cycle");

  // Clock run never stops a busy card, and resumes on the cycle after the card turns busy
  AST_IDLE_BEFORE_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cardClockStop) |-> $past(cardIdle) && ($past(s_q.idleCnt) >= IdleLast))
    else $error("clock stopped before the idle count");

  AST_CLK_RESUME: assert property (@(posedge clk) disable iff (!rst_b)
    (cardClockStop && !cardIdle) |=> !cardClockStop)
    else $error("card clock held stopped while card busy");

  COV_AUTO_STOP: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.clkStopSel && $rose(cardClockStop));
  COV_HOST_STOP: cover property (@(posedge clk) disable iff (!rst_b)
    !s_q.clkStopSel && $rose(cardClockStop));
  COV_REFUSED: cover property (@(posedge clk) disable iff (!rst_b) $rose(supplyRefused));
  COV_REENABLE: cover property (@(posedge clk) disable iff (!rst_b)
    !powerCtrlEnabled ##1 powerCtrlEnabled);
  COV_INTERROGATE: cover property (@(posedge clk) disable iff (!rst_b) cardInterrogatePulse);

endmodule : cssc_socket_ctrl
`default_nettype wire

/* File: verif/cssc_card_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cssc_card_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busy,
  input wire logic setCardBus,
  input wire logic [3:0] setSense,
  input wire logic [2:0] mainSupplyGrant,
  output logic cardIdle,
  output logic cardIsCardBus,
  output logic [3:0] cardSense,
  output logic overVolt
);
  logic levelOk;

  // Levels the card tolerates, sense order {Y,X,3.3V,5V}
  always_comb begin
    case (mainSupplyGrant)
      3'h0: levelOk = 1'b1;
      3'h2: levelOk = cardSense[0];
      3'h3: levelOk = cardSense[1];
      3'h4: levelOk = cardSense[2];
      3'h5: levelOk = cardSense[3];
      default: levelOk = 1'b0;
    endcase
  end

  // Card lines, plus a sticky flag for a supply the card cannot take
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cardIdle <= 1'b0;
      cardIsCardBus <= 1'b1;
      cardSense <= 4'h0;
      overVolt <= 1'b0;
    end else begin
      cardIdle <= !busy;
      cardIsCardBus <= setCardBus;
      cardSense <= setSense;
      if (cardIsCardBus && !levelOk) overVolt <= 1'b1;
    end
  end
endmodule : cssc_card_model

`default_nettype wire

/* File: verif/cssc_socket_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module cssc_socket_ctrl_bench;
  logic clk = 1'b0;
  logic rst_b, read, write, hostStopReq, busy, setCardBus;
  logic [7:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, setSense, cardSense;
  logic waitrequest, cardIdle, cardIsCardBus, cardClockStop, overVolt;
  logic videoPortEnable, videoPortActivity, supplyRefused, powerCtrlEnabled;
  logic cardInterrogatePulse;
  logic [2:0] mainSupplyGrant, progSupplyGrant;
  int errors = 0;
  int n_compared = 0;
  int pulses = 0;

  // Clock and pulse counter
  always #4 clk = ~clk;
  always @(posedge clk) if (cardInterrogatePulse === 1'b1) pulses <= pulses + 1;

  cssc_socket_ctrl #(.IDLE_CLOCKS(8)) dut_u (.clk(clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .cardIdle(cardIdle),
    .hostStopReq(hostStopReq), .cardIsCardBus(cardIsCardBus), .cardSense(cardSense),
    .cardClockStop(cardClockStop), .videoPortEnable(videoPortEnable),
    .videoPortActivity(videoPortActivity), .mainSupplyGrant(mainSupplyGrant),
    .progSupplyGrant(progSupplyGrant), .supplyRefused(supplyRefused),
    .powerCtrlEnabled(powerCtrlEnabled), .cardInterrogatePulse(cardInterrogatePulse));

  cssc_card_model card_u (.clk(clk), .rst_b(rst_b), .busy(busy), .setCardBus(setCardBus),
    .setSense(setSense), .mainSupplyGrant(mainSupplyGrant), .cardIdle(cardIdle),
    .cardIsCardBus(cardIsCardBus), .cardSense(cardSense), .overVolt(overVolt));

  // Verdict and end of run
  task automatic conclude();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // Let n edges pass, then look between edges
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : waitc

  // One Avalon transfer, held until a rising edge samples waitrequest low
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t >= 50) `CHK(waitrequest, 1'b0)
    // Same edge: write lands, read data taken, request released
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    access(1'b1, a, d, be, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    access(1'b0, a, 32'h0, 4'hf, q);
    `CHK(q, e)
  endtask : rdchk

  // Watchdog
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // Test sequence
  initial begin
    logic [2:0] e;
    int p;
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    hostStopReq = 1'b0;
    busy = 1'b1;
    setCardBus = 1'b1;
    setSense = 4'ha;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    waitc(1);
    `CHK(powerCtrlEnabled, 1'b1)
    `CHK(videoPortEnable, 1'b0)
    rdchk(`CSSC_OFS_CTRL, 32'h0000_0400);
    rdchk(`CSSC_OFS_STATUS, 32'h0000_0001);
    // Lane-wise writes of all ones, then clear
    wr(`CSSC_OFS_CTRL, 32'hffff_ffff, 4'h2);
    rdchk(`CSSC_OFS_CTRL, 32'h0000_0e00);
    `CHK(videoPortActivity, 1'b1)
    wr(`CSSC_OFS_CTRL, 32'h0000_00ff, 4'h1);
    rdchk(`CSSC_OFS_CTRL, 32'h0000_0ef7);
    wr(`CSSC_OFS_CTRL, 32'h0, 4'hf);
    rdchk(`CSSC_OFS_CTRL, 32'h0000_0400);
    `CHK(videoPortActivity, 1'b0)
    wr(8'h40, 32'hffff_ffff, 4'hf);
    rdchk(8'h40, 32'h0);
    rdchk(`CSSC_OFS_CTRL, 32'h0000_0400);
    wr(`CSSC_OFS_STATUS, 32'hffff_ffff, 4'hf);
    rdchk(`CSSC_OFS_STATUS, 32'h0000_0001);
    // Every main code; card takes 3.3 V and Y only
    for (int c = 0; c < 8; c++) begin
      e = (c == 3 || c == 5) ? 3'(c) : 3'h0;
      wr(`CSSC_OFS_CTRL, 32'(c) << 4, 4'h1);
      waitc(3);
      `CHK(mainSupplyGrant, e)
      `CHK(supplyRefused, (c != 0 && e == 3'h0))
      rdchk(`CSSC_OFS_CTRL, 32'h400 | (32'(c) << 4));
    end
    // Every programming code under a 3.3 V main supply
    for (int c = 0; c < 8; c++) begin
      e = (c == 1 || c == 3 || c == 5) ? 3'(c) : 3'h0;
      wr(`CSSC_OFS_CTRL, 32'h30 | 32'(c), 4'h1);
      waitc(3);
      `CHK(progSupplyGrant, e)
      `CHK(supplyRefused, (c != 0 && e == 3'h0))
      `CHK(mainSupplyGrant, 3'h3)
    end
    rdchk(`CSSC_OFS_CTRL, 32'h0000_0437);
    // 16-bit card gets a level the sense bits do not list
    wr(`CSSC_OFS_CTRL, 32'h0, 4'h1);
    @(posedge clk) setCardBus <= 1'b0;
    waitc(3);
    wr(`CSSC_OFS_CTRL, 32'h40, 4'h1);
    waitc(3);
    `CHK(mainSupplyGrant, 3'h4)
    wr(`CSSC_OFS_CTRL, 32'h0, 4'h1);
    waitc(3);
    @(posedge clk) setCardBus <= 1'b1;
    // Forced sense cuts power, interrogation restores it
    wr(`CSSC_OFS_CTRL, 32'h30, 4'h1);
    waitc(3);
    rdchk(`CSSC_OFS_STATUS, 32'h0000_0301);
    wr(`CSSC_OFS_FORCE, 32'h0000_0400, 4'h2);
    waitc(3);
    `CHK(powerCtrlEnabled, 1'b0)
    `CHK(mainSupplyGrant, 3'h0)
    p = pulses;
    wr(`CSSC_OFS_FORCE, 32'h0000_4000, 4'h2);
    waitc(3);
    `CHK(pulses - p, 1)
    `CHK(powerCtrlEnabled, 1'b1)
    `CHK(mainSupplyGrant, 3'h3)
    // Force and interrogate together: interrogation wins
    wr(`CSSC_OFS_FORCE, 32'h0000_4400, 4'h2);
    waitc(3);
    `CHK(powerCtrlEnabled, 1'b1)
    `CHK(pulses - p, 2)
    `CHK(mainSupplyGrant, 3'h3)
    // Clock stop, host-requested mode
    wr(`CSSC_OFS_CTRL, 32'h0, 4'hf);
    @(posedge clk) busy <= 1'b0;
    waitc(12);
    `CHK(cardClockStop, 1'b0)
    @(posedge clk) hostStopReq <= 1'b1;
    waitc(3);
    `CHK(cardClockStop, 1'b1)
    @(posedge clk) busy <= 1'b1;
    waitc(3);
    `CHK(cardClockStop, 1'b0)
    // Clock stop, idle-only mode
    wr(`CSSC_OFS_CTRL, 32'h80, 4'h1);
    @(posedge clk);
    hostStopReq <= 1'b0;
    busy <= 1'b0;
    waitc(8);
    `CHK(cardClockStop, 1'b0)
    waitc(1);
    `CHK(cardClockStop, 1'b1)
    rdchk(`CSSC_OFS_STATUS, 32'h0000_0005);
    @(posedge clk) busy <= 1'b1;
    waitc(3);
    `CHK(cardClockStop, 1'b0)
    // Card that takes only 5 V
    @(posedge clk) setSense <= 4'h1;
    wr(`CSSC_OFS_CTRL, 32'h20, 4'h1);
    waitc(3);
    `CHK(mainSupplyGrant, 3'h2)
    `CHK(supplyRefused, 1'b0)
    wr(`CSSC_OFS_CTRL, 32'h30, 4'h1);
    waitc(3);
    `CHK(mainSupplyGrant, 3'h0)
    `CHK(supplyRefused, 1'b1)
    `CHK(overVolt, 1'b0)
    conclude();
  end
endmodule : cssc_socket_ctrl_bench

`default_nettype wire
